// ### shared/rsm_consts.vh
// Constants for the reference switchover and monitor block
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH

// Register addresses on the decoded serial control port
`define RSM_ADDR_W 10
`define RSM_ADDR_REFCTL 10'h01c
`define RSM_ADDR_MONSEL 10'h01b
`define RSM_ADDR_STATUS 10'h0f0

// Reference control register fields
`define RSM_BIT_DEGLITCH_OFF 7
`define RSM_BIT_SEL_B 6
`define RSM_BIT_USE_PIN 5
`define RSM_BIT_AUTO 4
`define RSM_BIT_STAY_B 3
`define RSM_BIT_PWR_B 2
`define RSM_BIT_PWR_A 1
`define RSM_BIT_DIFF 0

// Reset values
`define RSM_REFCTL_RST 8'h00
`define RSM_MONSEL_RST 5'h00

// Monitor selector field
`define RSM_MONSEL_W 5
`define RSM_MON_INV_BIT 4

// Monitor source codes, low four bits of the selector
`define RSM_MON_RAIL 4'h0
`define RSM_MON_CLK_A 4'h1
`define RSM_MON_CLK_B 4'h2
`define RSM_MON_CLK_SEL 4'h3
`define RSM_MON_CLK_UNSEL 4'h4
`define RSM_MON_GOOD_SEL 4'h5
`define RSM_MON_GOOD_UNSEL 4'h6
`define RSM_MON_GOOD_A 4'h7
`define RSM_MON_GOOD_B 4'h8
`define RSM_MON_GOOD_AB 4'h9
`define RSM_MON_LOCK_ALL 4'ha
`define RSM_MON_GOOD_VCO 4'hb
`define RSM_MON_WHICH_REF 4'hc
`define RSM_MON_LOCK 4'hd
`define RSM_MON_HOLDOVER 4'he

// Switchover states
`define RSM_ON_A 1'b0
`define RSM_ON_B 1'b1

`endif

// ### core/rsm_deglitch.v
// Glitch-free two-way reference multiplexer for the PLL input
`timescale 1ns/1ns
`include "rsm_consts.vh"

module rsm_deglitch (
    input wire sys_clk, // System clock
    input wire rst, // Synchronous reset, active high
    input wire refA, // Synchronised reference input A
    input wire refB, // Synchronised reference input B
    input wire targetSel, // Wanted reference, 1 means input B
    input wire bypass, // High disables the deglitcher
    output reg pllRef_q, // Reference delivered to the PLL
    output reg activeSel_q // Reference in use, 1 means input B
);

    reg gate_q; // Output held low during a change over
    wire curClk; // Clock now in use
    wire newClk; // Clock about to be used

    assign curClk = activeSel_q ? refB : refA;
    assign newClk = targetSel ? refB : refA;

    // Change over only after the old clock and then the new clock are seen low, so no runt pulse escapes
    always @(posedge sys_clk) begin
        if (rst) begin
            gate_q <= 1'b0;
            activeSel_q <= `RSM_ON_A;
            pllRef_q <= 1'b0;
        end else if (bypass) begin
            // Deglitch off: follow the wanted reference at once
            gate_q <= 1'b0;
            activeSel_q <= targetSel;
            pllRef_q <= newClk;
        end else begin
            if (!gate_q && targetSel != activeSel_q && !curClk) begin
                // Old clock is low: freeze output low
                gate_q <= 1'b1;
            end else if (gate_q && !newClk) begin
                // New clock is low too: hand over
                gate_q <= 1'b0;
                activeSel_q <= targetSel;
            end
            // Output stays low while gated
            pllRef_q <= gate_q ? 1'b0 : curClk;
        end
    end

endmodule

// ### core/rsm_top.v
// Reference selection, switchover and monitor pin logic of the PLL
//
// Overview of operation
// - Code 10100 shows unselected clock, not differential.
// - 10101/10110 show selected/unselected good, active low; 10110 is held low if differential.
// - 10111/11000 show A/B frequency good, active low.
// - 11001 shows A good AND B good.
// - 11010 shows lock AND selected good AND VCO.
// - 11011 shows VCO good, active low.
// - 11100 low for input B, high for A.
// - 11101 lock, 11110 holdover, active low; 11111 unused.
// - Bit 6 picks input B in manual register mode.
// - Bit 5 picks selection from the select pin.
// - Automatic switchover powers both inputs, overrides enables.
// - Bit 3 clear reverts to A when good.
// - Bits 2 and 1 power inputs B and A.
// - Bit 0 selects differential reference mode.
// - Top selector bit clear gives active-high status.
`timescale 1ns/1ns
`include "rsm_consts.vh"

module rsm_top (
    input wire sys_clk, // System clock, 25 MHz
    input wire rst, // Synchronous reset, active high
    input wire [`RSM_ADDR_W-1:0] regAddr, // Register address
    input wire regWrEn, // Register write strobe, one cycle
    input wire [7:0] regWrData, // Register write data
    input wire regRdEn, // Register read strobe, one cycle
    output reg [7:0] regRdData_q, // Register read data, next cycle
    input wire refInputA, // Reference input A pin
    input wire refInputB, // Reference input B pin
    input wire refSelPin, // Reference select pin, high picks B
    input wire refAFreqGood, // Frequency monitor of input A, high is good
    input wire refBFreqGood, // Frequency monitor of input B, high is good
    input wire vcoFreqGood, // VCO frequency monitor, high is good
    input wire digitalLockDetect, // Digital lock detect, high is locked
    input wire holdoverActive, // Holdover controller active, high
    output wire pllRef, // Reference clock delivered to the PLL
    output wire refAPowerOn, // Power enable for input A buffer
    output wire refBPowerOn, // Power enable for input B buffer
    output wire diffRefMode, // High selects differential reference
    output reg refMonitorPin_q // Monitor pin output
);

    // Register state
    reg [7:0] refCtl_q; // Reference select control register
    reg [`RSM_MONSEL_W-1:0] monSel_q; // Monitor pin source selector
    reg autoSel_q; // Automatic switchover choice, 1 means input B
    reg [7:0] statusWord; // Read-only status view

    // Two-stage synchronisers for pins; only stage two is read
    reg [7:0] sync1_q; // First stage
    reg [7:0] sync2_q; // Second stage

    // Synchronised signals
    wire refA; // Input A clock
    wire refB; // Input B clock
    wire selPin; // Select pin
    wire goodA; // Input A frequency good
    wire goodB; // Input B frequency good
    wire goodVco; // VCO frequency good
    wire locked; // Digital lock detect
    wire holdover; // Holdover active

    // Control fields
    wire deglitchOff; // Bit 7
    wire regSelB; // Bit 6
    wire usePin; // Bit 5
    wire autoEn; // Bit 4
    wire stayOnB; // Bit 3
    wire pwrB; // Bit 2
    wire pwrA; // Bit 1
    wire diffMode; // Bit 0

    // Selection path
    reg targetSel; // Wanted reference, 1 means input B
    wire activeSel; // Reference now feeding the PLL
    wire selGood; // Good status of the selected reference
    wire unselGood; // Good status of the unselected reference
    wire selClk; // Selected reference clock
    wire unselClk; // Unselected reference clock
    reg monNext; // Next monitor pin level

    // Synchronous write strobes
    wire wrRefCtl; // Write to the reference control register
    wire wrMonSel; // Write to the monitor selector

    // Invert a status level when the top selector bit asks for it
    function statusLevel;
        input status; // Active-high status
        input invert; // Top selector bit
        begin
            statusLevel = invert ? ~status : status;
        end
    endfunction

    // Pin inputs cross into the clock domain through two flip-flops
    always @(posedge sys_clk) begin
        if (rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= {holdoverActive, digitalLockDetect, vcoFreqGood, refBFreqGood,
                refAFreqGood, refSelPin, refInputB, refInputA};
            sync2_q <= sync1_q;
        end
    end

    assign refA = sync2_q[0];
    assign refB = sync2_q[1];
    assign selPin = sync2_q[2];
    assign goodA = sync2_q[3];
    assign goodB = sync2_q[4];
    assign goodVco = sync2_q[5];
    assign locked = sync2_q[6];
    assign holdover = sync2_q[7];

    // Field decode of the control register
    assign deglitchOff = refCtl_q[`RSM_BIT_DEGLITCH_OFF];
    assign regSelB = refCtl_q[`RSM_BIT_SEL_B];
    assign usePin = refCtl_q[`RSM_BIT_USE_PIN];
    assign autoEn = refCtl_q[`RSM_BIT_AUTO];
    assign stayOnB = refCtl_q[`RSM_BIT_STAY_B];
    assign pwrB = refCtl_q[`RSM_BIT_PWR_B];
    assign pwrA = refCtl_q[`RSM_BIT_PWR_A];
    assign diffMode = refCtl_q[`RSM_BIT_DIFF];

    assign wrRefCtl = regWrEn && (regAddr == `RSM_ADDR_REFCTL);
    assign wrMonSel = regWrEn && (regAddr == `RSM_ADDR_MONSEL);

    // Register writes; the selector write never touches switchover state
    always @(posedge sys_clk) begin
        if (rst) begin
            refCtl_q <= `RSM_REFCTL_RST;
            monSel_q <= `RSM_MONSEL_RST;
        end else begin
            if (wrRefCtl) begin
                refCtl_q <= regWrData;
            end
            if (wrMonSel) begin
                // Only the selector changes here
                monSel_q <= regWrData[`RSM_MONSEL_W-1:0];
            end
        end
    end

    // Power enables: automatic switchover forces both inputs on
    assign refAPowerOn = autoEn | pwrA;
    assign refBPowerOn = autoEn | pwrB;
    // Differential mode is handed to the input buffers as a level
    assign diffRefMode = diffMode;

    // Automatic switchover choice
    // Software keeps single-ended mode while this runs; differential
    // mode still pins the choice to input A as a safe fallback.
    always @(posedge sys_clk) begin
        if (rst) begin
            autoSel_q <= `RSM_ON_A;
        end else if (!autoEn || diffMode) begin
            // Restart from input A whenever automatic mode resumes
            autoSel_q <= `RSM_ON_A;
        end else begin
            case (autoSel_q)
                `RSM_ON_A: begin
                    // Leave A only for a good B
                    if (!goodA && goodB) begin
                        autoSel_q <= `RSM_ON_B;
                    end
                end
                `RSM_ON_B: begin
                    if (goodA && !stayOnB) begin
                        // Revert to A once A is good again
                        autoSel_q <= `RSM_ON_A;
                    end else if (!goodB && goodA) begin
                        // B failed while A is good: go back even if staying
                        autoSel_q <= `RSM_ON_A;
                    end
                end
                default: begin
                    autoSel_q <= `RSM_ON_A;
                end
            endcase
        end
    end

    // Wanted reference from mode bits
    always @* begin
        if (diffMode) begin
            // Differential reference arrives on input A
            targetSel = `RSM_ON_A;
        end else if (autoEn) begin
            // Automatic switchover in charge
            targetSel = autoSel_q;
        end else if (usePin) begin
            // Manual choice from the select pin
            targetSel = selPin;
        end else begin
            // Manual choice from the register bit
            targetSel = regSelB;
        end
    end

    // Glitch-free change over toward the PLL
    rsm_deglitch u_deglitch (
        .sys_clk(sys_clk),
        .rst(rst),
        .refA(refA),
        .refB(refB),
        .targetSel(targetSel),
        .bypass(deglitchOff),
        .pllRef_q(pllRef),
        .activeSel_q(activeSel)
    );

    // Selected and unselected views; B is unavailable in differential mode
    assign selGood = activeSel ? goodB : goodA;
    assign unselGood = diffMode ? 1'b0 : (activeSel ? goodA : goodB);
    assign selClk = activeSel ? refB : refA;
    assign unselClk = diffMode ? 1'b0 : (activeSel ? refA : refB);

    // Monitor pin source; the top bit inverts level statuses other than 11001 and 11010, never clocks
    // Clocks are shown as sampled at the system clock, so references
    // above half the system rate alias on the pin.
    always @* begin
        monNext = 1'b0;
        case (monSel_q[3:0])
            `RSM_MON_RAIL: begin
                // Ground for the low half, supply for the high half
                monNext = monSel_q[`RSM_MON_INV_BIT];
            end
            `RSM_MON_CLK_A: begin
                monNext = refA;
            end
            `RSM_MON_CLK_B: begin
                monNext = diffMode ? 1'b0 : refB;
            end
            `RSM_MON_CLK_SEL: begin
                monNext = selClk;
            end
            `RSM_MON_CLK_UNSEL: begin
                // Dynamic unselected clock, quiet in differential mode
                monNext = unselClk;
            end
            `RSM_MON_GOOD_SEL: begin
                monNext = statusLevel(selGood, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_GOOD_UNSEL: begin
                // Forced low in differential mode, in both halves
                if (diffMode) begin
                    monNext = 1'b0;
                end else begin
                    monNext = statusLevel(unselGood, monSel_q[`RSM_MON_INV_BIT]);
                end
            end
            `RSM_MON_GOOD_A: begin
                monNext = statusLevel(goodA, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_GOOD_B: begin
                monNext = statusLevel(goodB, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_GOOD_AB: begin
                // Same polarity in both halves
                monNext = goodA & goodB;
            end
            `RSM_MON_LOCK_ALL: begin
                // Same polarity in both halves
                monNext = locked & selGood & goodVco;
            end
            `RSM_MON_GOOD_VCO: begin
                monNext = statusLevel(goodVco, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_WHICH_REF: begin
                // High half: high for A, low for B
                monNext = statusLevel(activeSel, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_LOCK: begin
                monNext = statusLevel(locked, monSel_q[`RSM_MON_INV_BIT]);
            end
            `RSM_MON_HOLDOVER: begin
                monNext = statusLevel(holdover, monSel_q[`RSM_MON_INV_BIT]);
            end
            default: begin
                // Reserved code drives low
                monNext = 1'b0;
            end
        endcase
    end

    // Monitor pin registered; a new source shows one edge after the write
    always @(posedge sys_clk) begin
        if (rst) begin
            refMonitorPin_q <= 1'b0;
        end else begin
            refMonitorPin_q <= monNext;
        end
    end

    // Read-only status view of the block's own state
    always @* begin
        statusWord = {1'b0, holdover, locked, goodVco, goodB, goodA,
            autoSel_q, activeSel};
    end

    // Register reads answer one cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk) begin
        if (rst) begin
            regRdData_q <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `RSM_ADDR_REFCTL: begin
                    regRdData_q <= refCtl_q;
                end
                `RSM_ADDR_MONSEL: begin
                    regRdData_q <= {3'h0, monSel_q};
                end
                `RSM_ADDR_STATUS: begin
                    regRdData_q <= statusWord;
                end
                default: begin
                    regRdData_q <= 8'h00;
                end
            endcase
        end
    end

endmodule

// ### tb/rsm_ref_src.sv
// Free-running model of the two reference clock sources
`timescale 1ns/1ns

module rsm_ref_src #(
    parameter HALF_A = 180, // Half period of source A in ns
    parameter HALF_B = 260 // Half period of source B in ns
) (
    output logic refA, // Clock from source A
    output logic refB // Clock from source B
);
    // Oscillators run free, so they toggle even while the input buffers are off
    initial begin
        refA = 1'b0;
        #3;
        forever #(HALF_A) refA = ~refA;
    end
    // A small start offset keeps every toggle off a system clock edge, so
    // the synchronisers never see a sampling race in simulation
    initial begin
        refB = 1'b0;
        #3;
        forever #(HALF_B) refB = ~refB;
    end
endmodule

// ### tb/rsm_top_checker.sv
// Concurrent assertions on the ports of the reference switchover block
`timescale 1ns/1ns
`include "rsm_consts.vh"

module rsm_top_checker (
    input wire sys_clk, // Clock
    input wire rst, // Reset
    input wire [`RSM_ADDR_W-1:0] regAddr, // Address
    input wire regWrEn, // Write strobe
    input wire [7:0] regWrData, // Write data
    input wire regRdEn, // Read strobe
    input wire [7:0] regRdData_q, // Read data
    input wire refInputA, // Reference A
    input wire refInputB, // Reference B
    input wire refSelPin, // Select pin
    input wire refAFreqGood, // A good
    input wire refBFreqGood, // B good
    input wire vcoFreqGood, // VCO good
    input wire digitalLockDetect, // Locked
    input wire holdoverActive, // Holdover
    input wire pllRef, // PLL reference
    input wire refAPowerOn, // A power
    input wire refBPowerOn, // B power
    input wire diffRefMode, // Differential
    input wire refMonitorPin_q // Monitor pin
);
    reg [4:0] monSel_q; // Shadow of the selector
    reg [7:0] ctl_q; // Shadow of the control register
    reg [2:0] live_q; // Edges since reset, saturates at 4
    wire ok = (live_q == 3'h4); // Pipeline flushed, so $past depth 3 is valid

    // Shadow the writable registers so outputs can be tied to their cause
    always @(posedge sys_clk) begin
        if (rst) begin
            monSel_q <= 5'h00;
            ctl_q <= 8'h00;
            live_q <= 3'h0;
        end else begin
            if (regWrEn && regAddr == `RSM_ADDR_MONSEL) begin
                monSel_q <= regWrData[4:0];
            end
            if (regWrEn && regAddr == `RSM_ADDR_REFCTL) begin
                ctl_q <= regWrData;
            end
            if (live_q != 3'h4) begin
                live_q <= live_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Status reaches the pin three edges after the input pin
    a_good_a_low: assert property (ok && $past(monSel_q) == 5'h17 |->
        refMonitorPin_q == !$past(refAFreqGood, 3)) else $error("good A level wrong");
    a_good_b_low: assert property (ok && $past(monSel_q) == 5'h18 |->
        refMonitorPin_q == !$past(refBFreqGood, 3)) else $error("good B level wrong");
    a_good_both: assert property (ok && $past(monSel_q) == 5'h19 |->
        refMonitorPin_q == $past(refAFreqGood & refBFreqGood, 3))
        else $error("good AND wrong");
    a_vco_low: assert property (ok && $past(monSel_q) == 5'h1b |->
        refMonitorPin_q == !$past(vcoFreqGood, 3)) else $error("VCO level wrong");
    a_lock_low: assert property (ok && $past(monSel_q) == 5'h1d |->
        refMonitorPin_q == !$past(digitalLockDetect, 3)) else $error("lock level wrong");
    a_hold_low: assert property (ok && $past(monSel_q) == 5'h1e |->
        refMonitorPin_q == !$past(holdoverActive, 3)) else $error("holdover level wrong");
    a_high_polarity: assert property (ok && $past(monSel_q) == 5'h07 |->
        refMonitorPin_q == $past(refAFreqGood, 3)) else $error("high polarity wrong");
    a_unsel_diff: assert property (ok && ctl_q[0] && $past(ctl_q[0]) &&
        $past(monSel_q) == 5'h14 |-> !refMonitorPin_q) else $error("unselected in diff");
    a_power_auto: assert property (refAPowerOn == (ctl_q[4] | ctl_q[1]) &&
        refBPowerOn == (ctl_q[4] | ctl_q[2])) else $error("power enable wrong");
    a_diff_mode: assert property (diffRefMode == ctl_q[0])
        else $error("differential mode wrong");
    a_ctl_read: assert property (regRdEn && regAddr == `RSM_ADDR_REFCTL |=>
        regRdData_q == $past(ctl_q)) else $error("control readback wrong");

    c_which_b: cover property (ok && $past(monSel_q) == 5'h1c && !refMonitorPin_q);
    c_auto_stay: cover property (ctl_q[4] && ctl_q[3]);
    c_diff_unsel: cover property (ctl_q[0] && monSel_q == 5'h14);
endmodule

bind rsm_top rsm_top_checker chk (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData_q(regRdData_q), .refInputA(refInputA), .refInputB(refInputB),
    .refSelPin(refSelPin), .refAFreqGood(refAFreqGood), .refBFreqGood(refBFreqGood),
    .vcoFreqGood(vcoFreqGood), .digitalLockDetect(digitalLockDetect),
    .holdoverActive(holdoverActive), .pllRef(pllRef), .refAPowerOn(refAPowerOn),
    .refBPowerOn(refBPowerOn), .diffRefMode(diffRefMode),
    .refMonitorPin_q(refMonitorPin_q));

// ### tb/tb_top.sv
// Self-checking testbench for the reference switchover and monitor block
`timescale 1ns/1ns
`include "rsm_consts.vh"

module tb_top;
    logic sys_clk = 1'b0; // 25 MHz clock
    logic rst = 1'b1; // Synchronous reset
    logic [9:0] regAddr = 10'h000; // Register address
    logic regWrEn = 1'b0; // Write strobe
    logic [7:0] regWrData = 8'h00; // Write data
    logic regRdEn = 1'b0; // Read strobe
    logic refSelPin = 1'b0; // Select pin
    logic [4:0] stat = 5'h00; // {A good, B good, VCO good, lock, holdover}
    logic [7:0] rdv; // Last read value
    logic hi, lo; // Pin levels seen while sampling a clock
    logic [3:0] highRun = 4'h0; // Edges the PLL reference has stayed high
    logic runtSeen = 1'b0; // A short high pulse reached the PLL
    logic watchRunt = 1'b0; // High while deglitched changes are expected
    wire refInputA, refInputB, pllRef, refAPowerOn, refBPowerOn, diffRefMode;
    wire [7:0] regRdData_q;
    wire refMonitorPin_q;
    int num_errors = 0;
    int tests_run = 0;
    // Rows: {selector, status, expected pin}, reference A selected manually
    logic [10:0] rows [18] = '{
        {5'h15, 5'h16, 1'h0}, {5'h15, 5'h0e, 1'h1}, {5'h16, 5'h16, 1'h1},
        {5'h17, 5'h18, 1'h0}, {5'h18, 5'h10, 1'h1}, {5'h19, 5'h18, 1'h1},
        {5'h19, 5'h17, 1'h0}, {5'h1a, 5'h16, 1'h1}, {5'h1a, 5'h1a, 1'h0},
        {5'h1b, 5'h04, 1'h0}, {5'h1b, 5'h1b, 1'h1}, {5'h1c, 5'h00, 1'h1},
        {5'h1d, 5'h02, 1'h0}, {5'h1e, 5'h1e, 1'h1}, {5'h1e, 5'h01, 1'h0},
        {5'h07, 5'h10, 1'h1}, {5'h0b, 5'h04, 1'h1}, {5'h1f, 5'h1f, 1'h0}};

    always #20 sys_clk = ~sys_clk;

    // Sampled reference pulses last at least four edges; a shorter one is a runt
    always @(posedge sys_clk) begin
        if (pllRef) begin
            highRun <= highRun + 4'h1;
        end else begin
            if (watchRunt && highRun != 4'h0 && highRun < 4'h4) begin
                runtSeen <= 1'b1;
            end
            highRun <= 4'h0;
        end
    end

    rsm_ref_src src (.refA(refInputA), .refB(refInputB));

    rsm_top dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
        .refInputA(refInputA), .refInputB(refInputB), .refSelPin(refSelPin),
        .refAFreqGood(stat[4]), .refBFreqGood(stat[3]), .vcoFreqGood(stat[2]),
        .digitalLockDetect(stat[1]), .holdoverActive(stat[0]), .pllRef(pllRef),
        .refAPowerOn(refAPowerOn), .refBPowerOn(refBPowerOn),
        .diffRefMode(diffRefMode), .refMonitorPin_q(refMonitorPin_q));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask

    // Read data appears one edge after the strobe and then stands
    task automatic rd(input logic [9:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        tick(1);
        rdv = regRdData_q;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic mon(input logic e, input string what);
        chk({7'h00, refMonitorPin_q}, {7'h00, e}, what);
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is under 2000 cycles, so 5000 means a hang
    initial begin
        #(40 * 5000);
        num_errors++;
        summarize;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        chk({refMonitorPin_q, refAPowerOn, refBPowerOn, diffRefMode}, 8'h00, "reset");
        chk({7'h00, pllRef}, 8'h00, "reference after reset");
        rd(`RSM_ADDR_REFCTL);
        chk(rdv, 8'h00, "control reset");
        wr(`RSM_ADDR_REFCTL, 8'h06);
        tick(1);
        chk({refAPowerOn, refBPowerOn}, 8'h03, "power enables");
        $display("reset and power test done");
        for (int i = 0; i < 18; i++) begin
            @(posedge sys_clk);
            stat <= rows[i][5:1];
            wr(`RSM_ADDR_MONSEL, {3'h0, rows[i][10:6]});
            tick(5);
            mon(rows[i][0], "monitor row");
        end
        rd(`RSM_ADDR_REFCTL);
        chk(rdv, 8'h06, "control after selector");
        rd(10'h3ff);
        chk(rdv, 8'h00, "unmapped read");
        $display("monitor table test done");
        // Unselected clock (B) must toggle on the pin in single-ended mode
        wr(`RSM_ADDR_MONSEL, 8'h14);
        hi = 1'b0;
        lo = 1'b0;
        repeat (40) begin
            tick(1);
            hi = hi | refMonitorPin_q;
            lo = lo | !refMonitorPin_q;
        end
        chk({hi, lo}, 8'h03, "unselected clock toggles");
        wr(`RSM_ADDR_REFCTL, 8'h01); // Power bits clear with differential set
        hi = 1'b0;
        repeat (30) begin
            tick(1);
            hi = hi | refMonitorPin_q;
        end
        chk({hi, diffRefMode}, 8'h01, "differential unselected");
        $display("unselected clock test done");
        // Every change from here to the bypass step goes through the deglitcher
        watchRunt = 1'b1;
        // Selection by register, pin and with the deglitcher bypassed
        @(posedge sys_clk);
        stat <= 5'h1e;
        wr(`RSM_ADDR_MONSEL, 8'h1c);
        wr(`RSM_ADDR_REFCTL, 8'h46);
        tick(60);
        mon(1'b0, "register picks B");
        wr(`RSM_ADDR_REFCTL, 8'h26);
        @(posedge sys_clk);
        refSelPin <= 1'b1;
        tick(60);
        mon(1'b0, "pin picks B");
        @(posedge sys_clk);
        refSelPin <= 1'b0;
        tick(60);
        mon(1'b1, "pin picks A");
        watchRunt = 1'b0;
        chk({7'h00, runtSeen}, 8'h00, "no runt pulse");
        wr(`RSM_ADDR_REFCTL, 8'hc6);
        // Bypass changes on the next edge; the deglitcher could not be this quick
        tick(2);
        mon(1'b0, "undeglitched switch");
        hi = 1'b0;
        lo = 1'b0;
        repeat (30) begin
            tick(1);
            hi = hi | pllRef;
            lo = lo | !pllRef;
        end
        chk({hi, lo}, 8'h03, "reference reaches PLL");
        $display("selection test done");
        // Automatic switchover, single-ended mode kept by software
        wr(`RSM_ADDR_REFCTL, 8'h10);
        tick(1);
        chk({refAPowerOn, refBPowerOn}, 8'h03, "auto powers both");
        @(posedge sys_clk);
        stat <= 5'h0e;
        tick(60);
        mon(1'b0, "auto to B");
        @(posedge sys_clk);
        stat <= 5'h1e;
        tick(60);
        mon(1'b1, "revert to A");
        wr(`RSM_ADDR_REFCTL, 8'h18);
        @(posedge sys_clk);
        stat <= 5'h0e;
        tick(60);
        @(posedge sys_clk);
        stat <= 5'h1e;
        tick(60);
        mon(1'b0, "stay on B");
        rd(`RSM_ADDR_STATUS);
        chk(rdv, 8'h3f, "status view");
        $display("automatic switchover test done");
        // Reset in mid-run must clear registers and outputs again
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        chk({refMonitorPin_q, refAPowerOn, refBPowerOn, pllRef}, 8'h00, "reset again");
        rd(`RSM_ADDR_REFCTL);
        chk(rdv, 8'h00, "control after reset");
        rd(`RSM_ADDR_MONSEL);
        chk(rdv, 8'h00, "selector after reset");
        $display("mid-run reset test done");
        summarize;
    end
endmodule
